// ===== hw/mcsr_consts.svh
/*
  Offsets, field positions, reset values and fixed figures for the
  core register bank. Assumes inclusion by its bare name.
*/
// Contract
// - Flag-affecting writes to flags register: Z, DC, C come from result.
// - Software writes never change watchdog-expiry or sleep-entered flags.
// - Add: carry set on carry out; subtract: carry set when no borrow.
// - Rotates load carry with bit shifted out, low or high bit.
// - Nibble flag: carry out of bit 3 add, inverted borrow subtract.
// - Zero flag set when result is zero, else cleared.
// - Sleep-entered flag set at reset and watchdog clear, cleared by sleep.
// - Expiry flag set at reset, watchdog clear, sleep; cleared on overflow.
// - Pointer bits 5:0 give indirect address; bits 7:6 read as ones.
// - Port reads return pin levels; writes update output latch only.
// - Unimplemented bits of power, enable and flag registers read zero.
// - Resistor option bit enables sensing on port A pins 0 and 1.
// - Ext select 0: port B pin 0 plain I/O, external path blocked.
// - Ext select 1: pin 0 is external input, its change path blocked.
// - Each wake enable bit lets its port B pin raise change and wake; pin 0 only with ext select 0.
// - PC high buffer holds one or two low bits by variant.
// - Pull-down bits active low, port A and B pins 3 to 0.
// - Open-drain bits active high, one per port B pin.
// - Pull-up bits active low, one per port B pin.
// - Enable bits 0,1,2 gate timer, change and external interrupts.
// - Wake with global enable 0 resumes; with 1 vectors to 008h.
// - Taken interrupt clears global enable; return-from-interrupt sets it.
// - Interrupt flags set by events, cleared only by software.
// - Writing PC low byte loads upper PC bits from high buffer.
// - Edge select 1 picks rising edge, 0 falling, for external flag.
`ifndef MCSR_CONSTS_SVH
`define MCSR_CONSTS_SVH
`define MCSR_IDX_FLAGS   6'h03
`define MCSR_IDX_PTR     6'h04
`define MCSR_IDX_PORT_A_DATA   6'h05
`define MCSR_IDX_PORT_B_DATA   6'h06
`define MCSR_IDX_PWR     6'h08
`define MCSR_IDX_WAKE    6'h09
`define MCSR_IDX_PCHB    6'h0A
`define MCSR_IDX_PDN     6'h0B
`define MCSR_IDX_ODR     6'h0C
`define MCSR_IDX_PUP     6'h0D
`define MCSR_IDX_IEN     6'h0E
`define MCSR_IDX_IFL     6'h0F
`define MCSR_B_CARRY     0
`define MCSR_B_NIBBLE    1
`define MCSR_B_ZERO      2
`define MCSR_B_SLEEP     3
`define MCSR_B_WDTX      4
`define MCSR_B_GIE       7
`define MCSR_PWR_MASK    8'hF0
`define MCSR_IEN_MASK    8'h87
`define MCSR_IFL_MASK    8'h07
`define MCSR_PTR_ONES    8'hC0
`define MCSR_RST_FLAGS   8'h18
`define MCSR_RST_ZERO    8'h00
`define MCSR_RST_PULL    8'hFF
`define MCSR_IRQ_VECTOR  10'h008
`endif

// ===== hw/mcsr_pkg.sv
/*
  Types for the core register bank.
  Assumes the core and the bank share one clock.
*/
package mcsr_pkg;
  typedef enum logic [2:0] {ALU_NONE, ALU_ADD, ALU_SUB, ALU_ROR, ALU_ROL, ALU_LOGIC} mcsr_alu_e;
  typedef enum logic {PWR_RUN, PWR_SLEEP} mcsr_pwr_e;
  typedef struct packed {
    mcsr_alu_e  op;
    logic [7:0] a;
    logic [7:0] b;
  } mcsr_alu_t;
  typedef struct packed {
    logic wdt_clear;
    logic sleep;
    logic wdt_ovf;
    logic tmr_ovf;
    logic return_from_irq_instr;
    logic irq_ack;
    logic pcl_write;
  } mcsr_evt_t;
endpackage

// ===== hw/mcsr_regs.sv
/*
  Core special-function register bank on APB: flags, pointer, ports,
  pin controls, power control, PC high buffer, interrupt logic.
  Assumes core events arrive on pclk; port pins are asynchronous.
*/
`timescale 1ns/1ns
`include "mcsr_consts.svh"
module mcsr_regs
  import mcsr_pkg::*;
#(
  parameter int PC_HI_BITS = 2
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire mcsr_alu_t          alu,
  input  wire mcsr_evt_t          evt,
  input  wire logic               irq_edge_select,
  input  wire logic [7:0]         pa_pin,
  input  wire logic [7:0]         pb_pin,
  output logic [7:0]              port_a_latch,
  output logic [7:0]              port_b_latch,
  output logic [7:0]              alu_and_reset_flags,
  output logic [5:0]              indirect_addr,
  output logic [7:0]              power_ctrl,
  output logic [7:0]              port_b_data_wake_enable,
  output logic [7:0]              pull_down_ctrl,
  output logic [7:0]              open_drain_ctrl,
  output logic [7:0]              pull_up_ctrl,
  output logic [PC_HI_BITS-1:0]   pc_upper_bits,
  output logic                    pc_upper_load,
  output logic                    irq_request,
  output logic                    wake_pulse,
  output logic                    wake_vector,
  output logic [9:0]              irq_vector_addr
);

  initial begin
    if (PC_HI_BITS < 1 || PC_HI_BITS > 2) begin
      $error("PC_HI_BITS must be 1 or 2");
    end
  end

  function automatic logic [3:0] alu_flags(input mcsr_alu_t op);
    // Returns {affect, zero, nibble, carry}
    logic [8:0] sum;
    logic [4:0] nib;
    sum = 9'h000;
    nib = 5'h00;
    alu_flags = 4'h0;
    case (op.op)
      ALU_ADD: begin
        sum = {1'b0, op.a} + {1'b0, op.b};
        nib = {1'b0, op.a[3:0]} + {1'b0, op.b[3:0]};
        alu_flags = {1'b1, sum[7:0] == 8'h00, nib[4], sum[8]};
      end
      ALU_SUB: begin
        sum = {1'b0, op.a} + {1'b0, ~op.b} + 9'h001;
        nib = {1'b0, op.a[3:0]} + {1'b0, ~op.b[3:0]} + 5'h01;
        alu_flags = {1'b1, sum[7:0] == 8'h00, nib[4], sum[8]};
      end
      ALU_LOGIC: alu_flags = {1'b1, op.a == 8'h00, 2'b00};
      default: alu_flags = 4'h0;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
    reg_hit = addr[1:0] == 2'b00 && addr[7:2] == idx;
  endfunction

  // APB slave, no wait states
  logic ready_q;
  logic err_q;
  logic [31:0] rdata_q;
  logic setup;
  logic wr_en;
  logic mapped;
  logic [7:0] wdat;
  assign setup  = psel && !penable && !ready_q;
  assign wr_en  = psel && penable && pwrite && ready_q && !err_q;
  assign wdat   = pwdata[7:0];

  // Pin synchronisers
  logic [7:0] pa_s1_q;
  logic [7:0] pa_s2_q;
  logic [7:0] pb_s1_q;
  logic [7:0] pb_s2_q;
  logic [7:0] pb_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_s1_q   <= 8'h00;
      pa_s2_q   <= 8'h00;
      pb_s1_q   <= 8'h00;
      pb_s2_q   <= 8'h00;
      pb_prev_q <= 8'h00;
    end else begin
      pa_s1_q   <= pa_pin;
      pa_s2_q   <= pa_s1_q;
      pb_s1_q   <= pb_pin;
      pb_s2_q   <= pb_s1_q;
      pb_prev_q <= pb_s2_q;
    end
  end

  // Registers
  logic [7:0] flags_q;
  logic [5:0] ptr_q;
  logic [7:0] pa_lat_q;
  logic [7:0] pb_lat_q;
  logic [7:0] pwr_q;
  logic [7:0] wake_q;
  logic [PC_HI_BITS-1:0] pchb_q;
  logic [7:0] pdn_q;
  logic [7:0] odr_q;
  logic [7:0] pup_q;
  logic [7:0] ien_q;
  logic [2:0] ifl_q;
  logic [PC_HI_BITS-1:0] pcu_q;
  logic pcu_ld_q;
  logic [3:0] af;
  assign af = alu_flags(alu);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `MCSR_RST_FLAGS;
    end else begin
      if (wr_en && reg_hit(paddr, `MCSR_IDX_FLAGS)) begin
        flags_q[7:5] <= wdat[7:5];
        if (alu.op == ALU_NONE) flags_q[2:0] <= wdat[2:0];
      end
      if (af[3]) begin
        flags_q[`MCSR_B_ZERO]   <= af[2];
        if (alu.op != ALU_LOGIC) begin
          flags_q[`MCSR_B_NIBBLE] <= af[1];
          flags_q[`MCSR_B_CARRY]  <= af[0];
        end
      end
      if (alu.op == ALU_ROR) begin
        flags_q[`MCSR_B_CARRY] <= alu.a[0];
      end
      if (alu.op == ALU_ROL) begin
        flags_q[`MCSR_B_CARRY] <= alu.a[7];
      end
      // Expiry and sleep bits move only on hardware events
      if (evt.wdt_clear) begin
        flags_q[`MCSR_B_SLEEP] <= 1'b1;
        flags_q[`MCSR_B_WDTX]  <= 1'b1;
      end else if (evt.sleep) begin
        flags_q[`MCSR_B_SLEEP] <= 1'b0;
        flags_q[`MCSR_B_WDTX]  <= 1'b1;
      end else if (evt.wdt_ovf) begin
        flags_q[`MCSR_B_WDTX]  <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q    <= 6'h00;
      pa_lat_q <= `MCSR_RST_ZERO;
      pb_lat_q <= `MCSR_RST_ZERO;
      pwr_q    <= `MCSR_RST_ZERO;
      wake_q   <= `MCSR_RST_ZERO;
      pchb_q   <= '0;
      pdn_q    <= `MCSR_RST_PULL;
      odr_q    <= `MCSR_RST_ZERO;
      pup_q    <= `MCSR_RST_PULL;
    end else if (wr_en) begin
      if (reg_hit(paddr, `MCSR_IDX_PTR)) ptr_q <= wdat[5:0];
      if (reg_hit(paddr, `MCSR_IDX_PORT_A_DATA)) pa_lat_q <= wdat;
      if (reg_hit(paddr, `MCSR_IDX_PORT_B_DATA)) pb_lat_q <= wdat;
      if (reg_hit(paddr, `MCSR_IDX_PWR)) pwr_q <= wdat & `MCSR_PWR_MASK;
      if (reg_hit(paddr, `MCSR_IDX_WAKE)) wake_q <= wdat;
      if (reg_hit(paddr, `MCSR_IDX_PCHB)) pchb_q <= wdat[PC_HI_BITS-1:0];
      if (reg_hit(paddr, `MCSR_IDX_PDN)) pdn_q <= wdat;
      if (reg_hit(paddr, `MCSR_IDX_ODR)) odr_q <= wdat;
      if (reg_hit(paddr, `MCSR_IDX_PUP)) pup_q <= wdat;
    end
  end

  // PC upper bits follow the buffer on every PC low byte write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcu_q    <= '0;
      pcu_ld_q <= 1'b0;
    end else begin
      pcu_ld_q <= evt.pcl_write;
      if (evt.pcl_write) pcu_q <= pchb_q;
    end
  end

  // Interrupt sources
  logic ext_sel;
  logic ext_evt;
  logic chg_evt;
  logic [7:0] chg_mask;
  logic [2:0] set_ev;
  logic [2:0] pend;
  logic ifl_wr;
  assign ifl_wr   = wr_en && reg_hit(paddr, `MCSR_IDX_IFL);
  assign ext_sel  = pwr_q[6];
  assign chg_mask = wake_q & {7'h7F, !ext_sel};
  assign chg_evt  = |((pb_s2_q ^ pb_prev_q) & chg_mask);
  assign ext_evt  = ext_sel && (irq_edge_select ?
                    (pb_s2_q[0] && !pb_prev_q[0]) : (!pb_s2_q[0] && pb_prev_q[0]));
  assign set_ev   = {ext_evt, chg_evt, evt.tmr_ovf};
  assign pend     = ifl_q & ien_q[2:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifl_q <= 3'h0;
    end else if (ifl_wr) begin
      ifl_q <= wdat[2:0] | set_ev;
    end else begin
      ifl_q <= ifl_q | set_ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_q <= `MCSR_RST_ZERO;
    end else begin
      if (wr_en && reg_hit(paddr, `MCSR_IDX_IEN)) ien_q <= wdat & `MCSR_IEN_MASK;
      if (evt.return_from_irq_instr) ien_q[`MCSR_B_GIE] <= 1'b1;
      else if (evt.irq_ack) ien_q[`MCSR_B_GIE] <= 1'b0;
    end
  end

  // Sleep tracking and wake
  mcsr_pwr_e pwr_st_q;
  logic irq_q;
  logic wake_p_q;
  logic wake_v_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_st_q <= PWR_RUN;
      wake_p_q <= 1'b0;
      wake_v_q <= 1'b0;
    end else begin
      wake_p_q <= 1'b0;
      case (pwr_st_q)
        PWR_RUN: if (evt.sleep) pwr_st_q <= PWR_SLEEP;
        PWR_SLEEP: begin
          if (|pend[2:1]) begin
            pwr_st_q <= PWR_RUN;
            wake_p_q <= 1'b1;
            wake_v_q <= ien_q[`MCSR_B_GIE];
          end
        end
        default: pwr_st_q <= PWR_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_q <= 1'b0;
    else irq_q <= ien_q[`MCSR_B_GIE] && |pend && !evt.irq_ack;
  end

  // Read path
  logic [7:0] rd;
  always_comb begin
    rd = 8'h00;
    mapped = 1'b1;
    case (1'b1)
      reg_hit(paddr, `MCSR_IDX_FLAGS): rd = flags_q;
      reg_hit(paddr, `MCSR_IDX_PTR):   rd = `MCSR_PTR_ONES | {2'b00, ptr_q};
      reg_hit(paddr, `MCSR_IDX_PORT_A_DATA): rd = pa_s2_q;
      reg_hit(paddr, `MCSR_IDX_PORT_B_DATA): rd = pb_s2_q;
      reg_hit(paddr, `MCSR_IDX_PWR):   rd = pwr_q;
      reg_hit(paddr, `MCSR_IDX_WAKE):  rd = wake_q;
      reg_hit(paddr, `MCSR_IDX_PCHB):  rd = {{(8-PC_HI_BITS){1'b0}}, pchb_q};
      reg_hit(paddr, `MCSR_IDX_PDN):   rd = pdn_q;
      reg_hit(paddr, `MCSR_IDX_ODR):   rd = odr_q;
      reg_hit(paddr, `MCSR_IDX_PUP):   rd = pup_q;
      reg_hit(paddr, `MCSR_IDX_IEN):   rd = ien_q;
      reg_hit(paddr, `MCSR_IDX_IFL):   rd = {5'h00, ifl_q};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ready_q <= setup;
      if (setup) begin
        err_q   <= !mapped;
        rdata_q <= {24'h00_0000, rd};
      end else if (ready_q) begin
        err_q <= 1'b0;
      end
    end
  end

  assign prdata              = rdata_q;
  assign pready              = ready_q;
  assign pslverr             = err_q;
  assign port_a_latch        = pa_lat_q;
  assign port_b_latch        = pb_lat_q;
  assign alu_and_reset_flags = flags_q;
  assign indirect_addr       = ptr_q;
  assign power_ctrl          = pwr_q;
  assign port_b_data_wake_enable   = wake_q;
  assign pull_down_ctrl      = pdn_q;
  assign open_drain_ctrl     = odr_q;
  assign pull_up_ctrl        = pup_q;
  assign pc_upper_bits       = pcu_q;
  assign pc_upper_load       = pcu_ld_q;
  assign irq_request         = irq_q;
  assign wake_pulse          = wake_p_q;
  assign wake_vector         = wake_v_q;
  assign irq_vector_addr     = `MCSR_IRQ_VECTOR;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence flags_wr_s;
    wr_en && reg_hit(paddr, `MCSR_IDX_FLAGS);
  endsequence

  alu_over_write_a: assert property (flags_wr_s and (alu.op == ALU_ADD) |=>
    flags_q[2:0] == $past(af[2:0])) else $error("flag write beat alu");
  reset_bits_hold_a: assert property (flags_wr_s and !evt.wdt_clear && !evt.sleep
    && !evt.wdt_ovf |=> $stable(flags_q[4:3])) else $error("reset flags written");
  sleep_clears_a: assert property (evt.sleep && !evt.wdt_clear |=>
    !flags_q[`MCSR_B_SLEEP] && flags_q[`MCSR_B_WDTX]) else $error("sleep flags wrong");
  wdt_ovf_clear_a: assert property (evt.wdt_ovf && !evt.wdt_clear && !evt.sleep |=>
    !flags_q[`MCSR_B_WDTX]) else $error("expiry not cleared");
  ptr_ones_a: assert property (setup && reg_hit(paddr, `MCSR_IDX_PTR) |=>
    pready && prdata[7:6] == 2'b11) else $error("pointer top bits");
  set_wins_a: assert property (evt.tmr_ovf |=> ifl_q[0]) else $error("flag set lost");
  gie_clear_a: assert property (evt.irq_ack && !evt.return_from_irq_instr |=>
    !ien_q[`MCSR_B_GIE]) else $error("global enable kept");
  pc_load_a: assert property (evt.pcl_write |=> pc_upper_load &&
    pc_upper_bits == $past(pchb_q)) else $error("pc upper not loaded");
  ext_block_a: assert property (!ext_sel && !ifl_wr |=>
    $stable(ifl_q[2])) else $error("ext flag set while blocked");

  sequence ext_rise_s;
    ext_sel && !pb_s2_q[0] ##1 ext_sel && pb_s2_q[0];
  endsequence

  sequence ext_fall_s;
    ext_sel && pb_s2_q[0] ##1 ext_sel && !pb_s2_q[0];
  endsequence

  ext_rise_a: assert property (ext_rise_s ##0 irq_edge_select |=>
    ifl_q[2]) else $error("rising edge missed");
  ext_fall_a: assert property (ext_fall_s ##0 !irq_edge_select |=>
    ifl_q[2]) else $error("falling edge missed");
  rot_right_a: assert property (alu.op == ALU_ROR |=>
    flags_q[`MCSR_B_CARRY] == $past(alu.a[0])) else $error("ror carry wrong");
  rot_left_a: assert property (alu.op == ALU_ROL |=>
    flags_q[`MCSR_B_CARRY] == $past(alu.a[7])) else $error("rol carry wrong");
  sub_carry_a: assert property (alu.op == ALU_SUB |=>
    flags_q[`MCSR_B_CARRY] == ($past(alu.a) >= $past(alu.b))) else $error("borrow wrong");
  add_nibble_a: assert property (alu.op == ALU_ADD |=>
    flags_q[`MCSR_B_NIBBLE] == (5'h00 + $past(alu.a[3:0]) + $past(alu.b[3:0]) > 5'h0F))
    else $error("nibble wrong");
  logic_keep_a: assert property (alu.op == ALU_LOGIC |=>
    flags_q[1:0] == $past(flags_q[1:0]) && flags_q[`MCSR_B_ZERO] == ($past(alu.a) == 8'h00))
    else $error("logic op flags wrong");
  irq_gate_a: assert property (!(|pend) |=> !irq_request) else $error("irq not gated");
  wake_vec_a: assert property (pwr_st_q == PWR_SLEEP && |pend[2:1] |=>
    wake_pulse && wake_vector == $past(ien_q[`MCSR_B_GIE])) else $error("wake vector wrong");
  flag_sticky_a: assert property (!ifl_wr |=> (ifl_q & $past(ifl_q)) == $past(ifl_q))
    else $error("flag cleared by hardware");
  unimpl_zero_a: assert property (pwr_q[3:0] == 4'h0 && ien_q[6:3] == 4'h0)
    else $error("unused bits set");
  port_read_a: assert property (setup && reg_hit(paddr, `MCSR_IDX_PORT_B_DATA) |=>
    prdata[7:0] == $past(pb_s2_q)) else $error("port read wrong");
endmodule

// ===== tb/mcsr_core_model.sv
/*
  Core-side model: replays one ALU op and event set per bench request.
  Assumes requests arrive on pclk rising edges, one cycle each.
*/
`timescale 1ns/1ns
module mcsr_core_model
  import mcsr_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      go,
  input  wire mcsr_alu_t req_alu,
  input  wire mcsr_evt_t req_evt,
  output mcsr_alu_t      alu,
  output mcsr_evt_t      evt
);
  // One-cycle pulses; idle operands keep moving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alu <= '{ALU_NONE, 8'h00, 8'h00};
      evt <= '0;
    end else if (go) begin
      alu <= req_alu;
      evt <= req_evt;
    end else begin
      alu <= '{ALU_NONE, ~alu.a, alu.a};
      evt <= '0;
    end
  end
endmodule

// ===== tb/mcsr_regs_tb.sv
/*
  Self-checking bench for the core register bank.
  Assumes the core model and the design are compiled before it.
*/
`timescale 1ns/1ns
module mcsr_regs_tb;
  import mcsr_pkg::*;
  localparam mcsr_evt_t  EV_NONE = 7'h00;
  localparam mcsr_evt_t  EV_CLR  = 7'h40;
  localparam mcsr_evt_t  EV_SLP  = 7'h20;
  localparam mcsr_evt_t  EV_OVF  = 7'h10;
  localparam mcsr_evt_t  EV_TMR  = 7'h08;
  localparam mcsr_evt_t  EV_RFI  = 7'h04;
  localparam mcsr_evt_t  EV_ACK  = 7'h02;
  localparam mcsr_evt_t  EV_PCL  = 7'h01;
  localparam logic [7:0] RA [9]  = '{8'h24, 8'h2C, 8'h30, 8'h34, 8'h20, 8'h38, 8'h3C, 8'h28, 8'h10};
  localparam logic [7:0] RV [9]  = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0};
  localparam logic [7:0] RM [9]  = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF0, 8'h87, 8'h07, 8'h03, 8'h3F};
  localparam logic [7:0] PW [7]  = '{8'h00, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40};
  localparam logic       ES [7]  = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam logic [7:0] PB [7]  = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h03, 8'h07};
  localparam logic [7:0] PX [7]  = '{8'h02, 8'h00, 8'h04, 8'h04, 8'h00, 8'h02, 8'h00};
  logic        pclk, presetn, psel, penable, pwrite, go, edge_sel, pc_upper_load;
  logic        pready, pslverr, irq_request, wake_pulse, wake_vector;
  logic [7:0]  paddr, pa_pin, pb_pin, port_a_latch, port_b_latch, fexp;
  logic [7:0]  flags_o, pwr_o, wake_o, pdn_o, odr_o, pup_o;
  logic [7:0]  wv [9];
  logic [5:0]  ptr_o;
  logic [9:0]  vec_o;
  logic [31:0] pwdata, prdata, seed, r;
  logic [1:0]  pc_upper_bits;
  mcsr_alu_t   req_alu, alu;
  mcsr_evt_t   req_evt, evt;
  mcsr_alu_e   op;
  logic [8:0]  exp_q[$];
  int          err_count, comparisons;

  mcsr_regs #(.PC_HI_BITS(2)) mcsr_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alu(alu), .evt(evt), .irq_edge_select(edge_sel), .pa_pin(pa_pin), .pb_pin(pb_pin),
    .port_a_latch(port_a_latch), .port_b_latch(port_b_latch), .alu_and_reset_flags(flags_o),
    .indirect_addr(ptr_o), .power_ctrl(pwr_o), .port_b_data_wake_enable(wake_o),
    .pull_down_ctrl(pdn_o), .open_drain_ctrl(odr_o), .pull_up_ctrl(pup_o),
    .pc_upper_bits(pc_upper_bits),
    .pc_upper_load(pc_upper_load), .irq_request(irq_request), .wake_pulse(wake_pulse),
    .wake_vector(wake_vector), .irq_vector_addr(vec_o));
  mcsr_core_model mcsr_core_model_inst (.pclk(pclk), .presetn(presetn), .go(go),
    .req_alu(req_alu), .req_evt(req_evt), .alu(alu), .evt(evt));

  always #5 pclk = ~pclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected zero, nibble, carry after one ALU op
  function automatic logic [2:0] alu_flags(mcsr_alu_e o, logic [7:0] a, b, logic [2:0] old);
    logic [7:0] bb;
    logic       c;
    logic [8:0] s;
    logic [4:0] h;
    c = (o == ALU_SUB);
    bb = c ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, c};
    h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, c};
    case (o)
      ALU_ROR: return {old[2:1], a[0]};
      ALU_ROL: return {old[2:1], a[7]};
      ALU_LOGIC: return {a == 8'h00, old[1:0]};
      default: return {s[7:0] == 8'h00, h[4], s[8]};
    endcase
  endfunction

  task automatic end_sim();
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Completed transfers checked against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      chk("apb", {pslverr, pwrite ? 8'h00 : prdata[7:0]}, exp_q.pop_front());
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, d, input logic [8:0] exp);
    int n;
    n = 0;
    exp_q.push_back(exp);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) begin
      err_count++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, e);
    apb(1'b0, a, 8'h00, {1'b0, e});
  endtask

  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d, 9'h000);
  endtask

  task automatic core(input mcsr_alu_e o, input logic [7:0] a, b, input mcsr_evt_t e);
    @(posedge pclk);
    go <= 1'b1;
    req_alu <= '{o, a, b};
    req_evt <= e;
    @(posedge pclk);
    go <= 1'b0;
  endtask

  task automatic ev(input mcsr_evt_t e);
    core(ALU_NONE, 8'h00, 8'h00, e);
  endtask

  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) begin
      err_count++;
      end_sim();
    end
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, go, edge_sel} = 7'h01;
    {paddr, pwdata, pb_pin, err_count, comparisons} = '0;
    req_alu = '{ALU_NONE, 8'h00, 8'h00};
    req_evt = EV_NONE;
    seed = 32'h9DDDE9AE;
    r = rnd();
    pa_pin = r[7:0];
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h0C, 8'h18);
    wr(8'h0C, 8'h00);
    rd(8'h0C, 8'h18);
    ev(EV_SLP);
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'hF7);
    ev(EV_OVF);
    rd(8'h0C, 8'hE7);
    ev(EV_CLR);
    rd(8'h0C, 8'hFF);
    fexp = 8'hFF;
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      op = mcsr_alu_e'(3'(1 + i % 5));
      if (i >= 5) r[15:8] = (op == ALU_SUB) ? r[7:0] : 8'h00 - r[7:0];
      if (i == 9) r[7:0] = 8'h00;
      core(op, r[7:0], r[15:8], EV_NONE);
      fexp[2:0] = alu_flags(op, r[7:0], r[15:8], fexp[2:0]);
      rd(8'h0C, fexp);
    end
    fork
      wr(8'h0C, 8'h00);
      core(ALU_ADD, 8'hFF, 8'h01, EV_NONE);
    join
    rd(8'h0C, {3'b000, fexp[4:3], 3'b111});
    apb(1'b0, 8'h1C, 8'h00, 9'h100);
    apb(1'b1, 8'h0D, 8'h5A, 9'h100);
    rd(8'h0C, {3'b000, fexp[4:3], 3'b111});
    fork
      wr(8'h0C, 8'hE0);
      core(ALU_LOGIC, 8'h5A, 8'h00, EV_NONE);
    join
    rd(8'h0C, {3'b111, fexp[4:3], 3'b011});
    chk("flags_out", {1'b0, flags_o}, {4'b0111, fexp[4:3], 3'b011});
    for (int i = 0; i < 9; i++) begin
      rd(RA[i], RV[i]);
      r = rnd();
      wv[i] = r[7:0];
      wr(RA[i], r[7:0]);
      rd(RA[i], r[7:0] & RM[i] | (i == 8 ? 8'hC0 : 8'h00));
    end
    chk("wake_out", {1'b0, wake_o}, {1'b0, wv[0]});
    chk("pull_down_out", {1'b0, pdn_o}, {1'b0, wv[1]});
    chk("open_drain_out", {1'b0, odr_o}, {1'b0, wv[2]});
    chk("pull_up_out", {1'b0, pup_o}, {1'b0, wv[3]});
    chk("power_out", {1'b0, pwr_o}, {1'b0, wv[4] & 8'hF0});
    chk("pointer_out", {3'b000, ptr_o}, {3'b000, wv[8][5:0]});
    chk("vector_out", {8'h00, vec_o == 10'h008}, 9'h001);
    rd(8'h14, pa_pin);
    wr(8'h14, ~pa_pin);
    @(posedge pclk);
    chk("port_a_latch", {1'b0, port_a_latch}, {1'b0, ~pa_pin});
    rd(8'h14, pa_pin);
    wr(8'h18, pa_pin);
    @(posedge pclk);
    chk("port_b_latch", {1'b0, port_b_latch}, {1'b0, pa_pin});
    wr(8'h28, 8'h02);
    ev(EV_PCL);
    wait_hi(pc_upper_load);
    chk("pc_upper_bits", {7'h00, pc_upper_bits}, 9'h002);
    wr(8'h24, 8'h03);
    wr(8'h38, 8'h00);
    wr(8'h3C, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(8'h20, PW[i]);
      edge_sel <= ES[i];
      pb_pin <= PB[i];
      repeat (6) @(posedge pclk);
      rd(8'h3C, PX[i]);
      wr(8'h3C, 8'h00);
    end
    rd(8'h18, 8'h07);
    for (int g = 0; g < 2; g++) begin
      wr(8'h3C, 8'h00);
      wr(8'h38, g ? 8'h82 : 8'h02);
      ev(EV_SLP);
      pb_pin <= pb_pin ^ 8'h02;
      wait_hi(wake_pulse);
      chk("wake_vector", {8'h00, wake_vector}, {8'h00, g[0]});
    end
    wait_hi(irq_request);
    rd(8'h3C, 8'h02);
    ev(EV_ACK);
    rd(8'h38, 8'h02);
    ev(EV_RFI);
    rd(8'h38, 8'h82);
    ev(EV_TMR);
    rd(8'h3C, 8'h03);
    wr(8'h3C, 8'h01);
    repeat (3) @(posedge pclk);
    chk("irq_request", {8'h00, irq_request}, 9'h000);
    wr(8'h38, 8'h81);
    wait_hi(irq_request);
    end_sim();
  end
endmodule
